// >>> rtl/partner_ability_cfg.svh
// Constants for the emulated link partner ability register.
// Overview of operation
// RULE1 - Register is read-only; writes change nothing.
// RULE2 - Upper sixteen bits reserved; serial view sixteen bits.
// RULE3 - Bit 15 next page always reads zero.
// RULE4 - Bit 14 acknowledge always reads one.
// RULE5 - Bit 13 remote fault always reads zero.
// RULE6 - Bit 9 T4 capability always reads zero.
// RULE7 - Selector bits 4:0 read 00001.
// RULE8 - Partner pause bits follow local pause advertisement.
// RULE9 - Both advertised: strap picks symmetric or asymmetric.
// RULE10 - Pause bits captured only at negotiation completion.
// RULE11 - Advertisement edits wait for next negotiation run.
// RULE12 - Bits 8:5 from duplex pin, straps, success.
// RULE13 - Straps sampled once when chip reset releases.
// RULE14 - Match gives full duplex, mismatch half duplex.
// RULE15 - All derived fields update together in one cycle.
`ifndef PARTNER_ABILITY_CFG_SVH
`define PARTNER_ABILITY_CFG_SVH
`define ABIL_NEXT_PAGE    15
`define ABIL_ACK          14
`define ABIL_FAULT        13
`define ABIL_RSVD12       12
`define ABIL_ASYM         11
`define ABIL_SYM          10
`define ABIL_T4           9
`define ABIL_SPD_HI       8
`define ABIL_SPD_LO       5
`define ABIL_SEL_HI       4
`define ABIL_SEL_VAL      5'h01
`define ABIL_SPD_10FD     4'h2
`define ABIL_SPD_100FD    4'h8
`define ABIL_SPD_10HD     4'h1
`define ABIL_SPD_100HD    4'h4
`define ABIL_SPD_NONE     4'h0
`define ABIL_PAUSE_NONE   2'h0
`define ABIL_RESET_WORD   16'h4001
`endif

// >>> rtl/partner_ability_pkg.sv
// Types shared by the emulated link partner ability logic.
package partner_ability_pkg;
  typedef logic [15:0] ability_word_type;
  typedef logic [31:0] reg_word_type;
  typedef enum logic [0:0] {STRAP_WAIT, STRAP_HELD} strap_state_type;
endpackage : partner_ability_pkg

// >>> rtl/strap_latch.sv
// Captures configuration straps once, on the first clock after reset release.
`timescale 1ns/1ns
`include "partner_ability_cfg.svh"
module strap_latch
  import partner_ability_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic strap_fc_in,
  input  wire logic strap_dpol_in,
  input  wire logic strap_speed_in,
  output logic      strap_fc_q,
  output logic      strap_dpol_q,
  output logic      strap_speed_q,
  output logic      strap_valid_q
);
  strap_state_type state_q;
  strap_state_type state_d;
  logic            fc_d;
  logic            dpol_d;
  logic            speed_d;

  // Sample while waiting, then freeze until the next chip reset.
  always_comb
  begin
    state_d = state_q;
    fc_d    = strap_fc_q;
    dpol_d  = strap_dpol_q;
    speed_d = strap_speed_q;
    unique case (state_q)
      STRAP_WAIT:
      begin
        fc_d    = strap_fc_in; // see RULE13
        dpol_d  = strap_dpol_in;
        speed_d = strap_speed_in;
        state_d = STRAP_HELD;
      end
      STRAP_HELD:
      begin
        state_d = STRAP_HELD;
      end
    endcase
  end

  // Reset holds constants only; the straps are caught after release.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q       <= STRAP_WAIT;
      strap_fc_q    <= 1'b0;
      strap_dpol_q  <= 1'b0;
      strap_speed_q <= 1'b0;
      strap_valid_q <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      strap_fc_q    <= fc_d;
      strap_dpol_q  <= dpol_d;
      strap_speed_q <= speed_d;
      strap_valid_q <= (state_d == STRAP_HELD);
    end
  end

  // Once held, the straps never change until reset.
  property p_strap_hold;
    @(posedge clk_sys) disable iff (srst)
    (state_q == STRAP_HELD) |=> $stable(strap_fc_q) && $stable(strap_speed_q)
      && $stable(strap_dpol_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // see RULE13
    else $error("Strap changed after capture.");
endmodule : strap_latch

// >>> rtl/emulated_link_partner_ability.sv
// Emulated link partner base-page ability register for the virtual PHY.
`timescale 1ns/1ns
`include "partner_ability_cfg.svh"
module emulated_link_partner_ability
  import partner_ability_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic                        pause_resolution_strap,
  input  wire logic                        duplex_pol_strap,
  input  wire logic                        speed_strap,
  input  wire logic                        port_zero_duplex_pin,
  input  wire logic [15:0]                 local_advertisement_reg,
  input  wire logic                        an_done,
  input  wire logic                        an_success,
  input  wire logic                        reg_wr,
  input  wire logic [31:0]                 reg_wdata,
  output partner_ability_pkg::reg_word_type emulated_partner_ability,
  output partner_ability_pkg::ability_word_type mii_rdata
);
  import partner_ability_pkg::*;

  logic             fc_strap;
  logic             dpol_strap;
  logic             spd_strap;
  logic             straps_ok;
  logic [1:0]       pause_q;
  logic [1:0]       pause_d;
  logic [3:0]       speed_q;
  logic [3:0]       speed_d;
  logic [1:0]       pause_new;
  logic [3:0]       speed_new;
  ability_word_type word_d;
  logic [31:0]      reg_q;
  logic [15:0]      mii_q;

  strap_latch u_straps (
    .clk_sys        (clk_sys),
    .srst           (srst),
    .strap_fc_in    (pause_resolution_strap),
    .strap_dpol_in  (duplex_pol_strap),
    .strap_speed_in (speed_strap),
    .strap_fc_q     (fc_strap),
    .strap_dpol_q   (dpol_strap),
    .strap_speed_q  (spd_strap),
    .strap_valid_q  (straps_ok)
  );

  // Resolve the partner pause pair {asym, sym} from the local advertisement.
  always_comb
  begin
    unique case ({local_advertisement_reg[`ABIL_ASYM],
                  local_advertisement_reg[`ABIL_SYM]})
      2'h0:    pause_new = `ABIL_PAUSE_NONE;       // see RULE8
      2'h1:    pause_new = 2'h1;                   // see RULE8
      2'h2:    pause_new = 2'h3;                   // see RULE8
      default: pause_new = fc_strap ? 2'h3 : 2'h2; // see RULE9
    endcase
  end

  // Speed and duplex pick follows pin against polarity strap.
  always_comb
  begin
    if (!an_success)
      speed_new = `ABIL_SPD_NONE; // see RULE12
    else if (port_zero_duplex_pin == dpol_strap)
      speed_new = spd_strap ? `ABIL_SPD_100FD : `ABIL_SPD_10FD; // see RULE14
    else
      speed_new = spd_strap ? `ABIL_SPD_100HD : `ABIL_SPD_10HD; // see RULE14
  end

  // Derived fields move only on completion, all in the same edge, so an
  // advertisement edit is invisible until negotiation runs again.
  always_comb
  begin
    pause_d = pause_q;
    speed_d = speed_q;
    if (an_done && straps_ok) // see RULE11
    begin
      pause_d = pause_new; // see RULE10
      speed_d = speed_new; // see RULE15
    end
  end

  // Assemble the word; fixed bits are constants, writes are never looked at.
  always_comb
  begin
    word_d = '0;
    word_d[`ABIL_NEXT_PAGE] = 1'b0; // see RULE3
    word_d[`ABIL_ACK]       = 1'b1; // see RULE4
    word_d[`ABIL_FAULT]     = 1'b0; // see RULE5
    word_d[`ABIL_T4]        = 1'b0; // see RULE6
    word_d[`ABIL_ASYM:`ABIL_SYM]       = pause_d;
    word_d[`ABIL_SPD_HI:`ABIL_SPD_LO]  = speed_d;
    word_d[`ABIL_SEL_HI:0]  = `ABIL_SEL_VAL; // see RULE7
  end

  // Register everything; outputs come straight from flip-flops.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pause_q <= `ABIL_PAUSE_NONE;
      speed_q <= `ABIL_SPD_NONE;
      reg_q   <= {16'h0000, `ABIL_RESET_WORD};
      mii_q   <= `ABIL_RESET_WORD;
    end
    else
    begin
      pause_q <= pause_d;
      speed_q <= speed_d;
      reg_q   <= {16'h0000, word_d}; // see RULE2
      mii_q   <= word_d;             // see RULE2
    end
  end

  // The write strobe and data are accepted and dropped: the register is RO.
  assign emulated_partner_ability = reg_q; // see RULE1
  assign mii_rdata                = mii_q;

  // Writes are dropped, so the word stands still across them.
  property p_write_ignored;
    @(posedge clk_sys) disable iff (srst)
    (reg_wr && !an_done) |=> $stable(reg_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored) // see RULE1
    else $error("Write altered read-only register.");

  // The padding half reads zero and the serial view mirrors the low half.
  property p_upper_zero;
    @(posedge clk_sys) disable iff (srst)
    reg_q[31:16] == 16'h0000 && reg_q[15:0] == mii_q;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // see RULE2
    else $error("Reserved half or serial view mismatch.");

  // Constant fields hold in every cycle, not only after a completion.
  property p_fixed_bits;
    @(posedge clk_sys) disable iff (srst)
    !reg_q[15] && reg_q[14] && !reg_q[13] && !reg_q[9]
      && !reg_q[12] && reg_q[4:0] == 5'h01;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) // see RULE3
    else $error("Fixed ability bits wrong.");

  // The pause result follows the advertisement seen at completion.
  property p_pause_table;
    @(posedge clk_sys) disable iff (srst)
    (an_done && straps_ok) |=> reg_q[11:10] ==
      (($past(local_advertisement_reg[11:10]) == 2'h0) ? 2'h0 :
       ($past(local_advertisement_reg[11:10]) == 2'h1) ? 2'h1 :
       ($past(local_advertisement_reg[11:10]) == 2'h2) ? 2'h3 :
       ($past(fc_strap) ? 2'h3 : 2'h2));
  endproperty
  a_pause_table: assert property (p_pause_table) // see RULE9
    else $error("Pause resolution wrong.");

  // Advertisement edits must wait for the next completion.
  property p_pause_hold;
    @(posedge clk_sys) disable iff (srst)
    !an_done |=> $stable(reg_q[11:10]);
  endproperty
  a_pause_hold: assert property (p_pause_hold) // see RULE11
    else $error("Pause bits moved without completion.");

  // Speed and duplex follow the pin against the polarity at completion.
  property p_speed_table;
    @(posedge clk_sys) disable iff (srst)
    (an_done && straps_ok && an_success) |=> reg_q[8:5] ==
      (($past(port_zero_duplex_pin) == $past(dpol_strap)) ?
       ($past(spd_strap) ? 4'h8 : 4'h2) : ($past(spd_strap) ? 4'h4 : 4'h1));
  endproperty
  a_speed_table: assert property (p_speed_table) // see RULE14
    else $error("Speed and duplex bits wrong.");

  // A failed run clears the speed and duplex bits.
  property p_speed_fail;
    @(posedge clk_sys) disable iff (srst)
    (an_done && straps_ok && !an_success) |=> reg_q[8:5] == 4'h0;
  endproperty
  a_speed_fail: assert property (p_speed_fail) // see RULE12
    else $error("Failed negotiation left ability bits set.");

  // Derived fields may only change in the cycle after a completion.
  property p_together;
    @(posedge clk_sys) disable iff (srst)
    $changed(reg_q[11:5]) |-> $past(an_done);
  endproperty
  a_together: assert property (p_together) // see RULE15
    else $error("Derived fields changed outside completion.");

  // Reset must leave both views at the idle word, fixed bits included.
  property p_reset_word;
    @(posedge clk_sys)
    srst |=> reg_q == {16'h0000, `ABIL_RESET_WORD}
      && mii_q == `ABIL_RESET_WORD;
  endproperty
  a_reset_word: assert property (p_reset_word) // see RULE4
    else $error("Reset word wrong.");

  // A completion seen before the straps are caught is refused.
  property p_early_refused;
    @(posedge clk_sys) disable iff (srst)
    (an_done && !straps_ok) |=> $stable(reg_q);
  endproperty
  a_early_refused: assert property (p_early_refused) // see RULE13
    else $error("Completion taken before straps were caught.");

  // Speed bits, like the pause bits, only move on a completion.
  property p_speed_hold;
    @(posedge clk_sys) disable iff (srst)
    !an_done |=> $stable(reg_q[8:5]);
  endproperty
  a_speed_hold: assert property (p_speed_hold) // see RULE12
    else $error("Speed bits moved without completion.");

  // Cover the main completions, a dropped write and the strap-picked pause.
  c_done_ok: cover property (@(posedge clk_sys) disable iff (srst)
    an_done && an_success && straps_ok);
  c_done_fail: cover property (@(posedge clk_sys) disable iff (srst)
    an_done && !an_success && straps_ok);
  c_write: cover property (@(posedge clk_sys) disable iff (srst) reg_wr);
  c_both_pause: cover property (@(posedge clk_sys) disable iff (srst)
    an_done && local_advertisement_reg[11:10] == 2'h3);
endmodule : emulated_link_partner_ability

// >>> verification/mgmt_host_model.sv
// Management host model that reads and writes the ability register.
`timescale 1ns/1ns
module mgmt_host_model
  import partner_ability_pkg::*;
(
  input  wire logic                             clk_sys,
  input  wire partner_ability_pkg::reg_word_type     reg_rdata,
  input  wire partner_ability_pkg::ability_word_type mii_rdata,
  output logic                                  reg_wr,
  output partner_ability_pkg::reg_word_type     reg_wdata
);
  import partner_ability_pkg::*;

  // Idle bus; released data shows the inverse of its last value.
  initial
  begin
    reg_wr    = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // One-cycle write strobe, launched and released at falling edges.
  task write_word(input reg_word_type d);
    @(negedge clk_sys);
    reg_wr    = 1'b1;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : write_word

  // Reads both views; the serial one is only sixteen bits wide.
  task read_word(output reg_word_type r, output ability_word_type m);
    @(negedge clk_sys);
    r = reg_rdata;
    m = mii_rdata;
  endtask : read_word
endmodule : mgmt_host_model

// >>> verification/emulated_link_partner_ability_tb_top.sv
// Self-checking testbench for the emulated partner ability register.
`timescale 1ns/1ns
module emulated_link_partner_ability_tb_top;
  import partner_ability_pkg::*;
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  logic             fc_s = 1'b0;
  logic             pol_s = 1'b0;
  logic             spd_s = 1'b0;
  logic             pin = 1'b0;
  logic [15:0]      adv = 16'h0000;
  logic             an_done = 1'b0;
  logic             an_success = 1'b0;
  logic             reg_wr;
  reg_word_type     reg_wdata;
  reg_word_type     rd32;
  ability_word_type mii;
  int               error_cnt = 0;
  int               num_checks = 0;

  // 50 MHz system clock.
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  emulated_link_partner_ability dut_u (.clk_sys(clk_sys), .srst(srst),
    .pause_resolution_strap(fc_s), .duplex_pol_strap(pol_s),
    .speed_strap(spd_s), .port_zero_duplex_pin(pin),
    .local_advertisement_reg(adv), .an_done(an_done),
    .an_success(an_success), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .emulated_partner_ability(rd32), .mii_rdata(mii));

  mgmt_host_model host_u (.clk_sys(clk_sys),
    .reg_rdata(rd32), .mii_rdata(mii), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));

  // Reads both views and compares them with one expected word.
  task check_word(input ability_word_type exp);
    reg_word_type     r;
    ability_word_type m;
    host_u.read_word(r, m);
    num_checks += 1;
    if ((r !== {16'h0000, exp}) || (m !== exp))
    begin
      error_cnt += 1;
      $display("BAD t=%0t got %h/%h exp %h", $time, r, m, exp);
    end
  endtask : check_word

  // Builds the word: ack and selector fixed, pause and speed derived.
  function automatic ability_word_type word(input logic [1:0] p,
                                            input logic [3:0] s);
    return {4'h4, p, 1'b0, s, 5'h01};
  endfunction : word

  // Straps are moved after capture to show they are held.
  task do_reset(input logic fc, input logic pol, input logic sp);
    @(negedge clk_sys);
    srst = 1'b1;
    {fc_s, pol_s, spd_s} = {fc, pol, sp};
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    {fc_s, pol_s, spd_s} = ~{fc, pol, sp};
    check_word(16'h4001);
  endtask : do_reset

  // One negotiation pulse, then a read of the result.
  task run_an(input logic [1:0] ap, input logic ok, input logic p,
              input ability_word_type exp);
    @(negedge clk_sys);
    adv        = 16'hF3FF & 16'hF3FF | {4'h0, ap, 10'h000};
    an_success = ok;
    pin        = p;
    an_done    = 1'b1;
    @(negedge clk_sys);
    an_done = 1'b0;
    check_word(exp);
  endtask : run_an

  // Every pause code, both resolutions of the double advertisement.
  task pause_table();
    do_reset(1'b1, 1'b0, 1'b0);
    run_an(2'b00, 1'b1, 1'b0, word(2'b00, 4'h2));
    run_an(2'b01, 1'b1, 1'b0, word(2'b01, 4'h2));
    run_an(2'b10, 1'b1, 1'b0, word(2'b11, 4'h2));
    run_an(2'b11, 1'b1, 1'b0, word(2'b11, 4'h2));
    do_reset(1'b0, 1'b0, 1'b0);
    run_an(2'b11, 1'b1, 1'b0, word(2'b10, 4'h2));
  endtask : pause_table

  // Pin against polarity at both speeds, then a failed negotiation.
  task speed_table();
    logic [3:0] s;
    for (int i = 0; i < 8; i++)
    begin
      do_reset(1'b1, i[2], i[1]);
      s = (i[0] == i[2]) ? (i[1] ? 4'h8 : 4'h2) : (i[1] ? 4'h4 : 4'h1);
      run_an(2'b01, 1'b1, i[0], word(2'b01, s));
    end
    run_an(2'b01, 1'b0, 1'b0, word(2'b01, 4'h0));
  endtask : speed_table

  // Advertisement edits and writes must not reach the register.
  task hold_value();
    run_an(2'b10, 1'b1, 1'b1, word(2'b11, 4'h8));
    adv = 16'h0000;
    repeat (3) @(negedge clk_sys);
    check_word(word(2'b11, 4'h8));
    host_u.write_word(32'hFFFF_FFFF);
    check_word(word(2'b11, 4'h8));
  endtask : hold_value

  // Completion in the first cycle after release comes before the straps
  // are caught and must be refused; the next one is taken.
  task early_done();
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (20) @(negedge clk_sys);
    srst       = 1'b0;
    adv        = 16'h0C00;
    an_success = 1'b1;
    an_done    = 1'b1;
    @(negedge clk_sys);
    an_done = 1'b0;
    check_word(word(2'b00, 4'h0));
    run_an(2'b01, 1'b1, 1'b0, word(2'b01, 4'h2));
  endtask : early_done

  // Prints the counts and the verdict, then ends the run.
  task print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial
  begin
    pause_table();
    speed_table();
    hold_value();
    early_done();
    print_verdict();
  end
endmodule : emulated_link_partner_ability_tb_top
